/* File: logic/fb_status_map.svh */
`ifndef FB_STATUS_MAP_SVH
`define FB_STATUS_MAP_SVH
// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define PFC_IDX 12'h016
`define SOS_IDX 12'h017
`define OVR_IDX 12'h01D
`define INF_IDX 12'h040
`define IDX_TO_ADDR(i) ((i) << 2)
`define ADDR_W 12
// ----------------------------------------
// reset values
// ----------------------------------------
`define PFC_RST 8'h06
`define SOS_RST 8'h00
`define OVR_RST 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define PRESC_MSB 2
`define PRESC_LSB 0
`define SEL_MSB 7
`define SEL_LSB 2
`define OVR_BIT 7
`define INF_DUAL_BIT 8
`define INF_PIN_BIT 16
`define INF_TOG_BIT 17
// ----------------------------------------
// prescaler codes and base ratios
// ----------------------------------------
`define PC_FD1 3'h0
`define PC_FD2 3'h1
`define PC_DM2 3'h2
`define PC_DM4 3'h3
`define PC_DM8 3'h4
`define PC_DM16 3'h5
`define PC_DM32 3'h6
`define PC_FD3 3'h7
`define RATIO_1 6'h01
`define RATIO_2 6'h02
`define RATIO_3 6'h03
`define RATIO_4 6'h04
`define RATIO_8 6'h08
`define RATIO_16 6'h10
`define RATIO_32 6'h20
`define RATIO_STEP 6'h01
// ----------------------------------------
// status selector codes
// ----------------------------------------
`define SEL_GND 6'h00
`define SEL_FB 6'h01
`define SEL_REF 6'h02
`define SEL_SWL 6'h03
`define SEL_PRE 6'h04
`define SEL_UP 6'h05
`define SEL_DN 6'h06
`define SEL_TOP 5
`define RM_GND 6'h20
`define RM_REF1 6'h21
`define RM_REF2 6'h22
`define RM_SREF 6'h23
`define RM_UREF 6'h24
`define RM_SOK 6'h25
`define RM_UOK 6'h26
`define RM_F1 6'h27
`define RM_F2 6'h28
`define RM_F12 6'h29
`define RM_LOCK 6'h2A
`define RM_VCO 6'h2B
`define RM_WHICH 6'h2C
`define RM_DLD 6'h2D
`define RM_HOLD 6'h2E
`define RM_LDC 6'h2F
`define RM_VS 6'h30
`endif

/* File: logic/fb_status_pkg.sv */
package fb_status_pkg;
  typedef enum logic {fixed_divide_mode, dual_modulus_mode} presc_kind_t;

  typedef struct packed {
    presc_kind_t kind;
    logic [5:0] base;
  } presc_cfg_t;

  typedef struct packed {
    logic fb_div_out;
    logic ref_div_out;
    logic swallow_out;
    logic phase_detector_up;
    logic phase_detector_down;
  } pll_nodes_t;

  typedef struct packed {
    logic ref1_clk;
    logic ref2_clk;
    logic sel_ref_clk;
    logic unsel_ref_clk;
    logic sel_ref_ok;
    logic unsel_ref_ok;
    logic ref1_freq_ok;
    logic ref2_freq_ok;
    logic vco_freq_ok;
    logic ref2_selected;
    logic digital_lock_detect;
    logic holdover_active;
    logic ld_comparator;
    logic supply_ok;
  } reference_monitor_pin_nodes_t;
endpackage : fb_status_pkg

/* File: logic/feedback_prescaler_status_select.sv */
// Summary of operation
// [R01] three-bit prescaler mode in feedback control
// [R02] fixed divide: 000 by 1, 001 by 2, 111 by 3
// [R03] code 010: by 3 if swallow nonzero, else 2
// [R04] code 011: by 5 if swallow nonzero, else 4
// [R05] code 100: by 9 if swallow nonzero, else 8
// [R06] code 101: by 17 if swallow nonzero, else 16
// [R07] code 110, default: by 33, else 32
// [R08] software clears override before changing selector
// [R09] selector 000000 or unlisted 0xxxxx: ground
// [R10] selector 000001: feedback divider output, toggling
// [R11] selector 000010: reference divider output, toggling
// [R12] codes 3 to 6: swallow, prescaler, up, down
// [R13] top bit set: reference monitor signal set
`timescale 1ns/100ps
`include "fb_status_map.svh"
module feedback_prescaler_status_select #(
  parameter int SWALLOW_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SWALLOW_W-1:0] swallow_count,
  input fb_status_pkg::pll_nodes_t pll_nodes,
  input fb_status_pkg::reference_monitor_pin_nodes_t reference_monitor_pin_nodes,
  output logic prescaler_out,
  output logic [5:0] prescaler_ratio,
  output logic prescaler_dual,
  output logic status_pin,
  output logic status_toggling
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  generate
    if (SWALLOW_W < 1)
    begin : g_bad_width
      $error("swallow counter width must be at least one");
    end
  endgenerate

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic fb_status_pkg::presc_cfg_t presc_decode(input logic [2:0] code);
    fb_status_pkg::presc_cfg_t c;
    c.kind = fb_status_pkg::dual_modulus_mode;
    c.base = `RATIO_32;
    case (code) // [R01]
      `PC_FD1: begin c.kind = fb_status_pkg::fixed_divide_mode; c.base = `RATIO_1; end // [R02]
      `PC_FD2: begin c.kind = fb_status_pkg::fixed_divide_mode; c.base = `RATIO_2; end // [R02]
      `PC_FD3: begin c.kind = fb_status_pkg::fixed_divide_mode; c.base = `RATIO_3; end // [R02]
      `PC_DM2: c.base = `RATIO_2; // [R03]
      `PC_DM4: c.base = `RATIO_4; // [R04]
      `PC_DM8: c.base = `RATIO_8; // [R05]
      `PC_DM16: c.base = `RATIO_16; // [R06]
      `PC_DM32: c.base = `RATIO_32; // [R07]
      default: c.base = `RATIO_32;
    endcase
    return c;
  endfunction : presc_decode

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] idx);
    return a == `ADDR_W'(`IDX_TO_ADDR(idx));
  endfunction : addr_hit

  // ----------------------------------------
  // registers and bus state
  // ----------------------------------------
  logic [7:0] pfc_r;
  logic [7:0] sos_r;
  logic [7:0] ovr_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [5:0] cnt_r;
  logic presc_out_r;
  logic [5:0] ratio_r;
  logic dual_r;
  logic pin_r;
  logic tog_r;

  logic setup_phase;
  logic wr_commit;
  logic hit_pfc;
  logic hit_sos;
  logic hit_ovr;
  logic hit_inf;
  logic hit_any;
  logic [31:0] rdata_nxt;
  fb_status_pkg::presc_cfg_t cfg;
  logic [5:0] ratio_nxt;
  logic [5:0] cnt_nxt;
  logic wrap;
  logic pin_nxt;
  logic tog_nxt;

  assign setup_phase = psel & ~penable & ~pready_r;
  assign wr_commit = psel & penable & pready_r & pwrite;
  assign hit_pfc = addr_hit(paddr, `PFC_IDX);
  assign hit_sos = addr_hit(paddr, `SOS_IDX);
  assign hit_ovr = addr_hit(paddr, `OVR_IDX);
  assign hit_inf = addr_hit(paddr, `INF_IDX);
  assign hit_any = hit_pfc | hit_sos | hit_ovr | hit_inf;

  // ----------------------------------------
  // apb handshake, no wait state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_r <= 1'b0;
    end
    else
    begin
      pslverr_r <= setup_phase & ~hit_any;
    end
  end

  // read data captured in setup so prdata comes from a flop
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_pfc)
    begin
      rdata_nxt[7:0] = pfc_r;
    end
    else if (hit_sos)
    begin
      rdata_nxt[7:0] = sos_r;
    end
    else if (hit_ovr)
    begin
      rdata_nxt[7:0] = ovr_r;
    end
    else if (hit_inf)
    begin
      rdata_nxt[5:0] = ratio_r;
      rdata_nxt[`INF_DUAL_BIT] = dual_r;
      rdata_nxt[`INF_PIN_BIT] = pin_r;
      rdata_nxt[`INF_TOG_BIT] = tog_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (setup_phase & ~pwrite)
    begin
      prdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pfc_r <= `PFC_RST; // [R07]
    end
    else if (wr_commit & hit_pfc)
    begin
      pfc_r <= pwdata[7:0]; // [R01]
    end
  end

  // selector write held off while override is set: keeps the pin stable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sos_r <= `SOS_RST; // [R09]
    end
    else if (wr_commit & hit_sos)
    begin
      sos_r[`SEL_LSB-1:0] <= pwdata[`SEL_LSB-1:0];
      if (!ovr_r[`OVR_BIT])
      begin
        sos_r[`SEL_MSB:`SEL_LSB] <= pwdata[`SEL_MSB:`SEL_LSB]; // [R08]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_r <= `OVR_RST;
    end
    else if (wr_commit & hit_ovr)
    begin
      ovr_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // prescaler ratio select
  // ----------------------------------------
  always_comb
  begin
    cfg = presc_decode(pfc_r[`PRESC_MSB:`PRESC_LSB]); // [R01]
    ratio_nxt = cfg.base;
    if (cfg.kind == fb_status_pkg::dual_modulus_mode && swallow_count != '0)
    begin
      ratio_nxt = cfg.base + `RATIO_STEP; // [R03] [R04] [R05] [R06] [R07]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ratio_r <= `RATIO_32;
    end
    else
    begin
      ratio_r <= ratio_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dual_r <= 1'b1;
    end
    else
    begin
      dual_r <= (cfg.kind == fb_status_pkg::dual_modulus_mode);
    end
  end

  // ----------------------------------------
  // prescaler counter
  // ----------------------------------------
  // pclk stands in for the vco edge; a shrinking ratio wraps at once
  always_comb
  begin
    wrap = (cnt_r + `RATIO_STEP) >= ratio_r;
    cnt_nxt = wrap ? 6'h00 : cnt_r + `RATIO_STEP;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 6'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_out_r <= 1'b0;
    end
    else
    begin
      presc_out_r <= wrap;
    end
  end

  // ----------------------------------------
  // status pin routing
  // ----------------------------------------
  status_mux u_status_mux (
    .sel(sos_r[`SEL_MSB:`SEL_LSB]),
    .pll(pll_nodes),
    .rm(reference_monitor_pin_nodes),
    .presc_pulse(presc_out_r),
    .pin(pin_nxt),
    .toggling(tog_nxt)
  );

  // one flop of latency traded for a glitch-free pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_r <= 1'b0; // [R09]
    end
    else
    begin
      pin_r <= pin_nxt; // [R10] [R11] [R12] [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tog_r <= 1'b0;
    end
    else
    begin
      tog_r <= tog_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prescaler_out = presc_out_r;
  assign prescaler_ratio = ratio_r;
  assign prescaler_dual = dual_r;
  assign status_pin = pin_r;
  assign status_toggling = tog_r;
endmodule : feedback_prescaler_status_select

/* File: logic/status_mux.sv */
`timescale 1ns/100ps
`include "fb_status_map.svh"
module status_mux (
  input wire logic [5:0] sel,
  input fb_status_pkg::pll_nodes_t pll,
  input fb_status_pkg::reference_monitor_pin_nodes_t rm,
  input wire logic presc_pulse,
  output logic pin,
  output logic toggling
);
  // ----------------------------------------
  // selector decode
  // ----------------------------------------
  always_comb
  begin
    pin = 1'b0;
    toggling = 1'b0;
    case (sel)
      `SEL_FB: begin pin = pll.fb_div_out; toggling = 1'b1; end // [R10]
      `SEL_REF: begin pin = pll.ref_div_out; toggling = 1'b1; end // [R11]
      `SEL_SWL: begin pin = pll.swallow_out; toggling = 1'b1; end // [R12]
      `SEL_PRE: begin pin = presc_pulse; toggling = 1'b1; end // [R12]
      `SEL_UP: begin pin = pll.phase_detector_up; toggling = 1'b1; end // [R12]
      `SEL_DN: begin pin = pll.phase_detector_down; toggling = 1'b1; end // [R12]
      `RM_REF1: begin pin = rm.ref1_clk; toggling = 1'b1; end // [R13]
      `RM_REF2: begin pin = rm.ref2_clk; toggling = 1'b1; end // [R13]
      `RM_SREF: begin pin = rm.sel_ref_clk; toggling = 1'b1; end // [R13]
      `RM_UREF: begin pin = rm.unsel_ref_clk; toggling = 1'b1; end // [R13]
      `RM_SOK: pin = rm.sel_ref_ok; // [R13]
      `RM_UOK: pin = rm.unsel_ref_ok; // [R13]
      `RM_F1: pin = rm.ref1_freq_ok; // [R13]
      `RM_F2: pin = rm.ref2_freq_ok; // [R13]
      `RM_F12: pin = rm.ref1_freq_ok & rm.ref2_freq_ok; // [R13]
      `RM_LOCK: pin = rm.digital_lock_detect & rm.sel_ref_ok & rm.vco_freq_ok; // [R13]
      `RM_VCO: pin = rm.vco_freq_ok; // [R13]
      `RM_WHICH: pin = rm.ref2_selected; // [R13]
      `RM_DLD: pin = rm.digital_lock_detect; // [R13]
      `RM_HOLD: pin = rm.holdover_active; // [R13]
      `RM_LDC: pin = rm.ld_comparator; // [R13]
      `RM_VS: pin = rm.supply_ok; // [R13]
      // ground for 000000, 100000 and every unlisted code
      default: pin = 1'b0; // [R09]
    endcase
  end
endmodule : status_mux

/* File: verification/fb_status_sva.sv */
`timescale 1ns/100ps
module fb_status_sva #(
  parameter int SWALLOW_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SWALLOW_W-1:0] swallow_count,
  input fb_status_pkg::reference_monitor_pin_nodes_t reference_monitor_pin_nodes,
  input wire logic prescaler_out,
  input wire logic [5:0] prescaler_ratio,
  input wire logic prescaler_dual,
  input wire logic status_pin,
  input wire logic status_toggling
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  sequence setup_s;
    psel && !penable && !pready;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  apb_answer_a: assert property (setup_s |=> access_s ##1 !pready)
    else $error("no single-cycle answer after setup");
  ready_alone_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  unmapped_err_a: assert property (setup_s |=>
    pslverr == !(paddr inside {12'h058, 12'h05C, 12'h074, 12'h100}))
    else $error("error flag disagrees with address map");
  // ----------------------------------------
  // prescaler and status
  // ----------------------------------------
  // first edge after release still holds the reset ratio
  dual_odd_a: assert property (
    $past(presetn) && prescaler_dual |-> prescaler_ratio[0] == (|$past(swallow_count)))
    else $error("dual ratio ignores swallow count");
  dual_set_a: assert property (prescaler_dual |-> prescaler_ratio inside
    {6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h10, 6'h11, 6'h20, 6'h21})
    else $error("illegal dual ratio");
  fixed_set_a: assert property (
    !prescaler_dual |-> prescaler_ratio inside {6'h01, 6'h02, 6'h03})
    else $error("illegal fixed ratio");
  ratio_one_a: assert property ((prescaler_ratio == 6'h01) [*3] |-> prescaler_out)
    else $error("divide by one not steady high");
  ground_hold_a: assert property (
    (!status_toggling && reference_monitor_pin_nodes == '0) [*3] |-> !status_pin)
    else $error("level source not grounded");
endmodule : fb_status_sva

/* File: verification/tb_feedback_prescaler_status_select.sv */
`timescale 1ns/100ps
module tb_feedback_prescaler_status_select;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] sw = 6'h00;
  fb_status_pkg::pll_nodes_t pn = '0;
  fb_status_pkg::reference_monitor_pin_nodes_t rm = '0;
  logic p_out;
  logic [5:0] ratio;
  logic dual;
  logic pin;
  logic tog;
  logic [32:0] expq[$];
  logic [32:0] e;
  logic [31:0] r;
  logic [2:0] c;
  logic [5:0] xr;
  logic dm;
  logic [7:0] n;
  int n_mismatch = 0;
  int n_tests = 0;
  always #4 pclk = ~pclk;
  feedback_prescaler_status_select #(.SWALLOW_W(6)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .swallow_count(sw), .pll_nodes(pn), .reference_monitor_pin_nodes(rm), .prescaler_out(p_out),
    .prescaler_ratio(ratio), .prescaler_dual(dual), .status_pin(pin),
    .status_toggling(tog));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_mismatch++;
      close_out();
    end
    else
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic check(input logic [32:0] want, input logic [32:0] got);
    n_tests++;
    if (want !== got)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, want, got);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    expq.push_back(x);
    apb(a, 1'b0, 32'h0);
  endtask : rd
  function automatic logic [5:0] ratio_of(input logic [2:0] k, input logic nz);
    case (k)
      3'h0: return 6'h01;
      3'h1: return 6'h02;
      3'h7: return 6'h03;
      default: return (6'h01 << (k - 3'h1)) + {5'h00, nz};
    endcase
  endfunction : ratio_of
  // {toggling, pin} expected for a selector code
  function automatic logic [1:0] stat_of(input logic [5:0] s);
    case (s)
      6'h01: return {1'b1, pn.fb_div_out};
      6'h02: return {1'b1, pn.ref_div_out};
      6'h03: return {1'b1, pn.swallow_out};
      6'h04: return 2'h3;
      6'h05: return {1'b1, pn.phase_detector_up};
      6'h06: return {1'b1, pn.phase_detector_down};
      6'h21: return {1'b1, rm.ref1_clk};
      6'h22: return {1'b1, rm.ref2_clk};
      6'h23: return {1'b1, rm.sel_ref_clk};
      6'h24: return {1'b1, rm.unsel_ref_clk};
      6'h25: return {1'b0, rm.sel_ref_ok};
      6'h26: return {1'b0, rm.unsel_ref_ok};
      6'h27: return {1'b0, rm.ref1_freq_ok};
      6'h28: return {1'b0, rm.ref2_freq_ok};
      6'h29: return {1'b0, rm.ref1_freq_ok & rm.ref2_freq_ok};
      6'h2A: return {1'b0, rm.digital_lock_detect & rm.sel_ref_ok & rm.vco_freq_ok};
      6'h2B: return {1'b0, rm.vco_freq_ok};
      6'h2C: return {1'b0, rm.ref2_selected};
      6'h2D: return {1'b0, rm.digital_lock_detect};
      6'h2E: return {1'b0, rm.holdover_active};
      6'h2F: return {1'b0, rm.ld_comparator};
      6'h30: return {1'b0, rm.supply_ok};
      default: return 2'h0;
    endcase
  endfunction : stat_of
  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expq.pop_front();
      n_tests++;
      if (e !== {pslverr, prdata})
      begin
        n_mismatch++;
        $display("wrong value at %0t: expected %h got %h", $time, e, {pslverr, prdata});
      end
    end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(67));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h058, 33'h006);
    rd(12'h05C, 33'h000);
    rd(12'h074, 33'h000);
    rd(12'h100, 33'h120);
    rd(12'h060, 33'h100000000);
    $display("reset test done");
    // upper write bits are random to show they are dropped
    for (int k = 0; k < 16; k++)
    begin
      c = 3'(k);
      r = $urandom();
      wr(12'h058, {r[31:8], 5'h00, c});
      sw <= (k < 8) ? 6'h00 : 6'($urandom_range(63, 1));
      repeat (2) @(posedge pclk);
      xr = ratio_of(c, k >= 8);
      dm = !(c inside {3'h0, 3'h1, 3'h7});
      rd(12'h100, {24'h0, dm, 2'b00, xr});
      rd(12'h058, {30'h0, c});
      check({26'h0, dm, xr}, {26'h0, dual, ratio});
      // a steady ratio gives exactly two pulses in two periods
      n = 8'h00;
      repeat (2 * xr)
      begin
        @(posedge pclk);
        n = n + {7'h00, p_out};
      end
      check(33'h2, {25'h0, n});
    end
    $display("prescaler test done");
    wr(12'h058, 32'h0);
    for (int s = 0; s < 64; s++)
    begin
      pn <= 5'($urandom());
      rm <= 14'($urandom());
      wr(12'h05C, {24'h0, 6'(s), 2'b00});
      repeat (2) @(posedge pclk);
      rd(12'h100, {15'h0, stat_of(6'(s)), 16'h0001});
      check({31'h0, stat_of(6'(s))}, {31'h0, tog, pin});
    end
    $display("selector test done");
    wr(12'h05C, 32'h04);
    wr(12'h074, 32'h80);
    wr(12'h05C, 32'h0B);
    rd(12'h05C, 33'h007);
    rd(12'h074, 33'h080);
    wr(12'h074, 32'h00);
    wr(12'h05C, 32'h08);
    rd(12'h05C, 33'h008);
    wr(12'h0FC, 32'hFF);
    $display("override test done");
    // mid-run reset: swallow count is still nonzero here
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h058, 33'h006);
    rd(12'h05C, 33'h000);
    rd(12'h074, 33'h000);
    rd(12'h100, 33'h121);
    $display("second reset test done");
    close_out();
  end
endmodule : tb_feedback_prescaler_status_select
bind feedback_prescaler_status_select fb_status_sva #(.SWALLOW_W(SWALLOW_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .swallow_count(swallow_count),
  .reference_monitor_pin_nodes(reference_monitor_pin_nodes), .prescaler_out(prescaler_out),
  .prescaler_ratio(prescaler_ratio), .prescaler_dual(prescaler_dual),
  .status_pin(status_pin), .status_toggling(status_toggling));
